// *** hdl/ccir_top.sv ***
// Status and error interrupt flags, line routing and enables behind an AHB-Lite slave
// What this block does
// - Per-channel test-symbol flags take the window result when each symbol window ends.
// - Wakeup-pattern flag sets in wakeup, ready, startup or monitor mode only.
// - Dynamic-segment-start flag sets at each dynamic segment start.
// - Buffer-status flag sets on status change of an enabled dedicated receive buffer.
// - Startup-success flag sets on entry to normal active from startup.
// - Stop-watch flag sets on each stop-watch trigger event.
// - Output-transfer flag sets on copy completion or output busy release.
// - Input-transfer flag sets on copy completion or input busy release.
// - Timer flags set on timer one and timer zero matches.
// - Network-management flag sets whenever the received vector changes.
// - FIFO-critical flag sets while fill level is at or above threshold.
// - FIFO-not-empty flag sets when a valid frame enters the FIFO.
// - Receive flag sets when payload lands in an enabled receive buffer.
// - Transmit flag sets after a frame leaves an enabled buffer.
// - Cycle-start flag sets at each communication cycle start.
// - Collision-symbol flag sets whenever that symbol is received.
// - Wakeup-status flag sets whenever the three-bit wakeup field changes.
// - Error line-select one routes that flag to second line, else first.
// - Status line-select one routes that flag to second line, else first.
// - Ones written at set address enable, at reset address disable; zeros ignored.
// - Both enable addresses read back the same error enable vector.
// - Only enabled error flags interrupt; enables at 26, 24, 18-16, 11-0.
// - Status flags stay set until written one, test-symbol flags also reload at window end; reset clears them all.
// - Each line has its own enable bit; disabled line stays low.
`timescale 1ns/1ps

module ccir_top (
    input  wire logic                   CLK,            // 250 MHz clock
    input  wire logic                   RST_B,          // Async reset, low active
    input  wire logic                   HSEL,           // Slave select
    input  wire logic [31:0]            HADDR,          // Byte address
    input  wire logic [1:0]             HTRANS,         // Transfer type
    input  wire logic                   HWRITE,         // Write when high
    input  wire logic [2:0]             HSIZE,          // Word only
    input  wire logic [31:0]            HWDATA,         // Write data
    input  wire logic                   HREADY,         // Bus ready
    output logic      [31:0]            HRDATA,         // Read data
    output logic                        HREADYOUT,      // Slave ready
    output logic                        HRESP,          // Always OKAY
    input  wire ccir_pkg::ccir_stat_ev_t STAT_EV,       // Status event sources
    input  wire logic [31:0]            ERR_EVENTS,     // Error event pulses
    input  wire logic [31:0]            STAT_IRQ_EN,    // Status enables, kept outside
    output logic                        IRQ_LINE_FIRST, // First interrupt line
    output logic                        IRQ_LINE_SECOND // Second interrupt line
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ccir_pkg::ccir_bus_st_t     bus_st_reg,     bus_st_next;
    logic [31:0]                addr_reg,       addr_next;
    logic                       wr_reg,         wr_next;
    logic [31:0]                rdata_reg,      rdata_next;
    logic                       rdy_reg,        rdy_next;
    logic [31:0]                stat_flags_reg, stat_flags_next;
    logic [31:0]                err_flags_reg,  err_flags_next;
    logic [31:0]                stat_lsel_reg,  stat_lsel_next;
    logic [31:0]                err_lsel_reg,   err_lsel_next;
    logic [31:0]                err_en_reg,     err_en_next;
    logic [1:0]                 line_en_reg,    line_en_next;
    logic [1:0]                 irq_reg,        irq_next;
    logic [3:0]                 poc_prev_reg,   poc_prev_next;
    logic                       obusy_prev_reg, obusy_prev_next;
    logic                       ibusy_prev_reg, ibusy_prev_next;
    logic [ccir_pkg::NMV_W-1:0] nmv_prev_reg,   nmv_prev_next;
    logic [2:0]                 wsv_prev_reg,   wsv_prev_next;
    logic                       primed_reg,     primed_next;

    // Decoded access strobes and hardware set/clear vectors
    logic        accept;
    logic        do_wr;
    logic        do_rd;
    logic [31:0] stat_set;
    logic [31:0] stat_clr;
    logic [31:0] err_clr;
    logic        wake_mode;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------

    // Address phase taken, then one wait cycle does the access
    assign accept = HSEL && HTRANS[1] && HREADY && (bus_st_reg == ccir_pkg::ST_IDLE);
    assign do_wr  = (bus_st_reg == ccir_pkg::ST_DATA) && wr_reg;
    assign do_rd  = (bus_st_reg == ccir_pkg::ST_DATA) && !wr_reg;

    // Next state of the bus slave and read mux
    always_comb begin
        bus_st_next = bus_st_reg;
        addr_next   = addr_reg;
        wr_next     = wr_reg;
        rdata_next  = rdata_reg;
        rdy_next    = rdy_reg;
        case (bus_st_reg)
            ccir_pkg::ST_IDLE: begin
                if (accept) begin
                    addr_next   = HADDR;
                    wr_next     = HWRITE;
                    rdy_next    = 1'b0;
                    bus_st_next = ccir_pkg::ST_DATA;
                end
            end
            ccir_pkg::ST_DATA: begin
                rdy_next    = 1'b1;
                bus_st_next = ccir_pkg::ST_IDLE;
                rdata_next  = ccir_pkg::RST_WORD;
                if (!wr_reg) begin
                    if (addr_reg == ccir_pkg::ADDR_ERR_FLAGS) begin
                        rdata_next = err_flags_reg;
                    end else if (addr_reg == ccir_pkg::ADDR_STAT_FLAGS) begin
                        rdata_next = stat_flags_reg;
                    end else if (addr_reg == ccir_pkg::ADDR_ERR_LSEL) begin
                        rdata_next = err_lsel_reg;
                    end else if (addr_reg == ccir_pkg::ADDR_STAT_LSEL) begin
                        rdata_next = stat_lsel_reg;
                    end else if (addr_reg == ccir_pkg::ADDR_LINE_EN) begin
                        rdata_next = {30'h0, line_en_reg};
                    end else if ((addr_reg == ccir_pkg::ADDR_ERR_EN_SET) ||
                                 (addr_reg == ccir_pkg::ADDR_ERR_EN_CLR)) begin
                        rdata_next = err_en_reg;
                    end
                end
            end
            default: begin
                bus_st_next = ccir_pkg::ST_IDLE;
                rdy_next    = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Status event decode
    // ------------------------------------------------------------

    // Wakeup patterns count only in the listed modes
    assign wake_mode = (STAT_EV.poc_state == ccir_pkg::POC_WAKEUP)  ||
                       (STAT_EV.poc_state == ccir_pkg::POC_READY)   ||
                       (STAT_EV.poc_state == ccir_pkg::POC_STARTUP) ||
                       (STAT_EV.poc_state == ccir_pkg::POC_MONITOR);

    // Hardware set terms, one bit per status flag
    always_comb begin
        stat_set = ccir_pkg::RST_WORD;
        stat_set[ccir_pkg::B_MTS_B] = STAT_EV.sym_window_end && STAT_EV.mts_seen_b;
        stat_set[ccir_pkg::B_MTS_A] = STAT_EV.sym_window_end && STAT_EV.mts_seen_a;
        stat_set[ccir_pkg::B_WUP_B] = wake_mode && STAT_EV.wake_pattern_b;
        stat_set[ccir_pkg::B_WUP_A] = wake_mode && STAT_EV.wake_pattern_a;
        stat_set[ccir_pkg::B_DSEG]  = STAT_EV.dyn_segment_began;
        stat_set[ccir_pkg::B_BSTAT] = STAT_EV.buf_status_change &&
                                      STAT_EV.buf_dedicated_rx && STAT_EV.buf_irq_enable;
        stat_set[ccir_pkg::B_SUCC]  = primed_reg &&
                                      (poc_prev_reg == ccir_pkg::POC_STARTUP) &&
                                      (STAT_EV.poc_state == ccir_pkg::POC_NACTIVE);
        stat_set[ccir_pkg::B_SWE]   = STAT_EV.stopwatch_event;
        stat_set[ccir_pkg::B_OUTX]  = STAT_EV.out_transfer_done ||
                                      (obusy_prev_reg && !STAT_EV.out_buffer_busy);
        stat_set[ccir_pkg::B_INX]   = STAT_EV.in_transfer_done ||
                                      (ibusy_prev_reg && !STAT_EV.in_buffer_busy);
        stat_set[ccir_pkg::B_TMR_B] = STAT_EV.timer_b_match;
        stat_set[ccir_pkg::B_TMR_A] = STAT_EV.timer_a_match;
        stat_set[ccir_pkg::B_NMV]   = primed_reg &&
                                      (nmv_prev_reg != STAT_EV.netmgmt_vector);
        stat_set[ccir_pkg::B_FCRIT] = STAT_EV.fifo_fill_level >= STAT_EV.fifo_threshold;
        stat_set[ccir_pkg::B_FNE]   = STAT_EV.fifo_frame_stored;
        stat_set[ccir_pkg::B_RX]    = STAT_EV.rx_payload_stored && STAT_EV.rx_buf_irq_enable;
        stat_set[ccir_pkg::B_TX]    = STAT_EV.tx_frame_sent && STAT_EV.tx_buf_irq_enable;
        stat_set[ccir_pkg::B_CYC]   = STAT_EV.cycle_began;
        stat_set[ccir_pkg::B_COLL]  = STAT_EV.collision_symbol_rx;
        stat_set[ccir_pkg::B_WAKE]  = primed_reg &&
                                      (wsv_prev_reg != STAT_EV.wake_status_field);
    end

    // Clear terms: write-one-to-clear, plus test-symbol flags dropped at window end
    always_comb begin
        stat_clr = ccir_pkg::RST_WORD;
        err_clr  = ccir_pkg::RST_WORD;
        if (do_wr && (addr_reg == ccir_pkg::ADDR_STAT_FLAGS)) begin
            stat_clr = HWDATA;
        end
        if (do_wr && (addr_reg == ccir_pkg::ADDR_ERR_FLAGS)) begin
            err_clr = HWDATA;
        end
        if (STAT_EV.sym_window_end) begin
            stat_clr[ccir_pkg::B_MTS_B] = 1'b1;
            stat_clr[ccir_pkg::B_MTS_A] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Flags, configuration and edge history
    // ------------------------------------------------------------

    // Set wins over clear; configuration written in the data phase
    always_comb begin
        stat_flags_next = ((stat_flags_reg & ~stat_clr) | stat_set) & ccir_pkg::STAT_MASK;
        err_flags_next  = ((err_flags_reg & ~err_clr) | ERR_EVENTS) & ccir_pkg::ERR_MASK;
        stat_lsel_next  = stat_lsel_reg;
        err_lsel_next   = err_lsel_reg;
        err_en_next     = err_en_reg;
        line_en_next    = line_en_reg;
        if (do_wr) begin
            if (addr_reg == ccir_pkg::ADDR_ERR_LSEL) begin
                err_lsel_next = HWDATA & ccir_pkg::ERR_MASK;
            end else if (addr_reg == ccir_pkg::ADDR_STAT_LSEL) begin
                stat_lsel_next = HWDATA & ccir_pkg::STAT_MASK;
            end else if (addr_reg == ccir_pkg::ADDR_LINE_EN) begin
                line_en_next = HWDATA[1:0] & ccir_pkg::LINE_EN_MASK;
            end else if (addr_reg == ccir_pkg::ADDR_ERR_EN_SET) begin
                err_en_next = err_en_reg | (HWDATA & ccir_pkg::ERR_EN_MASK);
            end else if (addr_reg == ccir_pkg::ADDR_ERR_EN_CLR) begin
                err_en_next = err_en_reg & ~(HWDATA & ccir_pkg::ERR_EN_MASK);
            end
        end
        poc_prev_next   = STAT_EV.poc_state;
        obusy_prev_next = STAT_EV.out_buffer_busy;
        ibusy_prev_next = STAT_EV.in_buffer_busy;
        nmv_prev_next   = STAT_EV.netmgmt_vector;
        wsv_prev_next   = STAT_EV.wake_status_field;
        primed_next     = 1'b1;
    end

    // Line outputs: routed, enabled, set flags ORed and gated per line
    always_comb begin
        irq_next[ccir_pkg::LINE_FIRST] = line_en_reg[ccir_pkg::LINE_FIRST] &&
            (|(stat_flags_reg & STAT_IRQ_EN & ~stat_lsel_reg) ||
             |(err_flags_reg & err_en_reg & ~err_lsel_reg));
        irq_next[ccir_pkg::LINE_SECOND] = line_en_reg[ccir_pkg::LINE_SECOND] &&
            (|(stat_flags_reg & STAT_IRQ_EN & stat_lsel_reg) ||
             |(err_flags_reg & err_en_reg & err_lsel_reg));
    end

    // All registers of the block
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            bus_st_reg     <= ccir_pkg::ST_IDLE;
            addr_reg       <= ccir_pkg::RST_WORD;
            wr_reg         <= 1'b0;
            rdata_reg      <= ccir_pkg::RST_WORD;
            rdy_reg        <= 1'b1;
            stat_flags_reg <= ccir_pkg::RST_WORD;
            err_flags_reg  <= ccir_pkg::RST_WORD;
            stat_lsel_reg  <= ccir_pkg::RST_WORD;
            err_lsel_reg   <= ccir_pkg::RST_WORD;
            err_en_reg     <= ccir_pkg::RST_WORD;
            line_en_reg    <= ccir_pkg::RST_LINE_EN;
            irq_reg        <= 2'h0;
            poc_prev_reg   <= 4'h0;
            obusy_prev_reg <= 1'b0;
            ibusy_prev_reg <= 1'b0;
            nmv_prev_reg   <= '0;
            wsv_prev_reg   <= 3'h0;
            primed_reg     <= 1'b0;
        end else begin
            bus_st_reg     <= bus_st_next;
            addr_reg       <= addr_next;
            wr_reg         <= wr_next;
            rdata_reg      <= rdata_next;
            rdy_reg        <= rdy_next;
            stat_flags_reg <= stat_flags_next;
            err_flags_reg  <= err_flags_next;
            stat_lsel_reg  <= stat_lsel_next;
            err_lsel_reg   <= err_lsel_next;
            err_en_reg     <= err_en_next;
            line_en_reg    <= line_en_next;
            irq_reg        <= irq_next;
            poc_prev_reg   <= poc_prev_next;
            obusy_prev_reg <= obusy_prev_next;
            ibusy_prev_reg <= ibusy_prev_next;
            nmv_prev_reg   <= nmv_prev_next;
            wsv_prev_reg   <= wsv_prev_next;
            primed_reg     <= primed_next;
        end
    end

    // Outputs straight from flops; HRESP tied low
    assign HRDATA          = rdata_reg;
    assign HREADYOUT       = rdy_reg;
    assign HRESP           = 1'b0;
    assign IRQ_LINE_FIRST  = irq_reg[ccir_pkg::LINE_FIRST];
    assign IRQ_LINE_SECOND = irq_reg[ccir_pkg::LINE_SECOND];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    // Flag set and hold
    chk_set_beats_clear: assert property (
        (|stat_set) |=> ((($past(stat_set) & ccir_pkg::STAT_MASK) & ~stat_flags_reg) == 32'h0000_0000))
        else $error("status flag lost its set event");

    chk_flag_holds: assert property (
        ##1 ((~stat_flags_reg & $past(stat_flags_reg) & ~$past(stat_clr)) == 32'h0000_0000))
        else $error("status flag fell without a clear");

    // Error enable register
    chk_en_set_write: assert property (
        (do_wr && addr_reg == ccir_pkg::ADDR_ERR_EN_SET) |=>
        ((err_en_reg & $past(HWDATA) & ccir_pkg::ERR_EN_MASK) == ($past(HWDATA) & ccir_pkg::ERR_EN_MASK)))
        else $error("error enable set write failed");

    chk_en_clr_write: assert property (
        (do_wr && addr_reg == ccir_pkg::ADDR_ERR_EN_CLR) |=>
        ((err_en_reg & $past(HWDATA)) == 32'h0000_0000) && ((err_en_reg & ~$past(HWDATA)) == $past(err_en_reg & ~HWDATA)))
        else $error("error enable clear write failed");

    chk_en_read_same: assert property (
        (do_rd && (addr_reg == ccir_pkg::ADDR_ERR_EN_SET || addr_reg == ccir_pkg::ADDR_ERR_EN_CLR))
        |=> (HRDATA == err_en_reg) && HREADYOUT)
        else $error("enable readback differs");

    // Line gating and routing
    chk_line_disabled: assert property (
        !line_en_reg[ccir_pkg::LINE_SECOND] |=> !IRQ_LINE_SECOND)
        else $error("disabled second line asserted");

    chk_status_first: assert property (
        (line_en_reg[ccir_pkg::LINE_FIRST] && |(stat_flags_reg & STAT_IRQ_EN & ~stat_lsel_reg)) |=> IRQ_LINE_FIRST)
        else $error("routed status flag missed first line");

    chk_error_second: assert property (
        (line_en_reg[ccir_pkg::LINE_SECOND] && |(err_flags_reg & err_en_reg & err_lsel_reg)) |=> IRQ_LINE_SECOND)
        else $error("routed error flag missed second line");

    // Startup detect and bus timing
    chk_startup_flag: assert property (
        (primed_reg && poc_prev_reg == ccir_pkg::POC_STARTUP && STAT_EV.poc_state == ccir_pkg::POC_NACTIVE)
        |=> stat_flags_reg[ccir_pkg::B_SUCC])
        else $error("startup success not flagged");

    chk_bus_wait: assert property (
        accept |=> !HREADYOUT ##1 HREADYOUT)
        else $error("bus answer timing wrong");

    // Event sources reaching their flags; lines quiet with nothing enabled and set
    chk_mts_window: assert property (
        STAT_EV.sym_window_end |=> (stat_flags_reg[ccir_pkg::B_MTS_B] == $past(STAT_EV.mts_seen_b)))
        else $error("test symbol flag missed window end");

    chk_wake_refused: assert property (
        (STAT_EV.poc_state == ccir_pkg::POC_NACTIVE && !stat_flags_reg[ccir_pkg::B_WUP_A]) |=>
        !stat_flags_reg[ccir_pkg::B_WUP_A])
        else $error("wake pattern flagged outside wake modes");

    chk_out_release: assert property (
        $fell(STAT_EV.out_buffer_busy) |=> stat_flags_reg[ccir_pkg::B_OUTX])
        else $error("output busy release not flagged");

    chk_nmv_change: assert property (
        ($past(RST_B) && $changed(STAT_EV.netmgmt_vector)) |=> stat_flags_reg[ccir_pkg::B_NMV])
        else $error("vector change not flagged");

    chk_fifo_level: assert property (
        (STAT_EV.fifo_fill_level >= STAT_EV.fifo_threshold) |=> stat_flags_reg[ccir_pkg::B_FCRIT])
        else $error("critical fill level not flagged");

    chk_cycle_flag: assert property (
        STAT_EV.cycle_began |=> stat_flags_reg[ccir_pkg::B_CYC])
        else $error("cycle start not flagged");

    chk_lines_quiet: assert property (
        !(|(err_flags_reg & err_en_reg) || |(stat_flags_reg & STAT_IRQ_EN)) |=>
        !IRQ_LINE_FIRST && !IRQ_LINE_SECOND)
        else $error("line raised with nothing enabled and set");

    // Main scenarios
    cov_write_clear: cover property (do_wr && addr_reg == ccir_pkg::ADDR_STAT_FLAGS && |(HWDATA & stat_flags_reg));
    cov_second_line: cover property (IRQ_LINE_SECOND);
    cov_set_and_clear: cover property (|(stat_set & stat_clr));
    cov_startup_seen: cover property (stat_set[ccir_pkg::B_SUCC]);
    cov_refused_wake: cover property (STAT_EV.wake_pattern_a && !wake_mode);

endmodule

// *** hdl/ccir_pkg.sv ***
// Package: register map, field layouts and event carrier for the interrupt status block
package ccir_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_ERR_FLAGS   = 32'h0000_0000;
    localparam logic [31:0] ADDR_STAT_FLAGS  = 32'h0000_0004;
    localparam logic [31:0] ADDR_ERR_LSEL    = 32'h0000_0008;
    localparam logic [31:0] ADDR_STAT_LSEL   = 32'h0000_000c;
    localparam logic [31:0] ADDR_LINE_EN     = 32'h0000_0010;
    localparam logic [31:0] ADDR_ERR_EN_SET  = 32'h0000_0030;
    localparam logic [31:0] ADDR_ERR_EN_CLR  = 32'h0000_0034;

    // ------------------------------------------------------------
    // Implemented bit masks and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] STAT_MASK   = 32'h0303_ffff;
    localparam logic [31:0] ERR_MASK    = 32'h0707_0fff;
    localparam logic [31:0] ERR_EN_MASK = 32'h0507_0fff;
    localparam logic [1:0]  LINE_EN_MASK = 2'h3;
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;
    localparam logic [1:0]  RST_LINE_EN = 2'h0;
    localparam int LINE_FIRST  = 0;
    localparam int LINE_SECOND = 1;

    // ------------------------------------------------------------
    // Status flag positions
    // ------------------------------------------------------------
    localparam int B_MTS_B = 25;
    localparam int B_WUP_B = 24;
    localparam int B_MTS_A = 17;
    localparam int B_WUP_A = 16;
    localparam int B_DSEG  = 15;
    localparam int B_BSTAT = 14;
    localparam int B_SUCC  = 13;
    localparam int B_SWE   = 12;
    localparam int B_OUTX  = 11;
    localparam int B_INX   = 10;
    localparam int B_TMR_B = 9;
    localparam int B_TMR_A = 8;
    localparam int B_NMV   = 7;
    localparam int B_FCRIT = 6;
    localparam int B_FNE   = 5;
    localparam int B_RX    = 4;
    localparam int B_TX    = 3;
    localparam int B_CYC   = 2;
    localparam int B_COLL  = 1;
    localparam int B_WAKE  = 0;

    // ------------------------------------------------------------
    // Protocol state codes and widths
    // ------------------------------------------------------------
    localparam logic [3:0] POC_WAKEUP  = 4'h1;
    localparam logic [3:0] POC_READY   = 4'h2;
    localparam logic [3:0] POC_STARTUP = 4'h3;
    localparam logic [3:0] POC_MONITOR = 4'h4;
    localparam logic [3:0] POC_NACTIVE = 4'h5;
    localparam int NMV_W = 96;

    // Event inputs from the protocol engine, handler, FIFO and timers
    typedef struct packed {
        logic             sym_window_end;
        logic             mts_seen_a;
        logic             mts_seen_b;
        logic             wake_pattern_a;
        logic             wake_pattern_b;
        logic [3:0]       poc_state;
        logic             dyn_segment_began;
        logic             buf_status_change;
        logic             buf_dedicated_rx;
        logic             buf_irq_enable;
        logic             stopwatch_event;
        logic             out_transfer_done;
        logic             out_buffer_busy;
        logic             in_transfer_done;
        logic             in_buffer_busy;
        logic             timer_b_match;
        logic             timer_a_match;
        logic [NMV_W-1:0] netmgmt_vector;
        logic [7:0]       fifo_fill_level;
        logic [7:0]       fifo_threshold;
        logic             fifo_frame_stored;
        logic             rx_payload_stored;
        logic             rx_buf_irq_enable;
        logic             tx_frame_sent;
        logic             tx_buf_irq_enable;
        logic             cycle_began;
        logic             collision_symbol_rx;
        logic [2:0]       wake_status_field;
    } ccir_stat_ev_t;

    // Bus slave states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DATA = 2'b10
    } ccir_bus_st_t;

endpackage

// *** tb/ccir_host_model.sv ***
// Host-side model: keeps a sticky record of both interrupt lines
`timescale 1ns/1ps
module ccir_host_model (
    input  wire logic       clk,   // Host clock
    input  wire logic       rst_b, // Reset, low active
    input  wire logic [1:0] irq,   // Lines from the block
    output logic      [1:0] seen   // Lines seen high since reset
);
    // Sticky capture of each line level
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) seen <= 2'h0;
        else seen <= seen | irq;
    end
endmodule

// *** tb/tb_comm_ctrl_interrupt_status_routing.sv ***
// Self-checking bench for the interrupt status block
`timescale 1ns/1ps
module tb_comm_ctrl_interrupt_status_routing;
    logic                    clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_phase = 1'b0;
    logic [1:0]              htrans = 2'h0;
    logic [31:0]             haddr = 32'h0, hwdata = 32'h0, err_ev = 32'h0, stat_en = 32'h0, hrdata, r;
    logic                    hready, irq0, irq1, hresp;
    logic [1:0]              seen;
    ccir_pkg::ccir_stat_ev_t ev = '0, pw = '0, pc = '0, px = '0;
    logic [31:0]             exp_q[$];
    int                      fail_count = 0, n_checks = 0, seed = 12408, cyc = 0;
    // Clock
    always #2 clk = ~clk;
    ccir_top u_ccir_top (.CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .STAT_EV(ev), .ERR_EVENTS(err_ev), .STAT_IRQ_EN(stat_en), .IRQ_LINE_FIRST(irq0), .IRQ_LINE_SECOND(irq1));
    ccir_host_model u_ccir_host_model (.clk(clk), .rst_b(rst_b), .irq({irq1, irq0}), .seen(seen));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Read data checked against the oldest note as each read completes
    always @(posedge clk) begin
        if (rd_phase && hready === 1'b1) chk(hrdata, exp_q.pop_front());
    end
    // Single transfer: address phase held until ready, then data phase until ready
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= d; rd_phase <= !w;
        do @(posedge clk); while (hready !== 1'b1);
        rd_phase <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // One-cycle event pulses, then time for flag and line to follow
    task automatic pulse(input ccir_pkg::ccir_stat_ev_t p, input logic [31:0] e);
        @(posedge clk);
        ev <= ev | p; err_ev <= e;
        @(posedge clk);
        ev <= ev & ~p; err_ev <= 32'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end
    // Main sequence
    initial begin
        pw.wake_pattern_a = 1'b1;
        pc.cycle_began = 1'b1;
        px.sym_window_end = 1'b1;
        px.mts_seen_b = 1'b1;
        px.dyn_segment_began = 1'b1;
        px.stopwatch_event = 1'b1;
        px.out_buffer_busy = 1'b1;
        px.timer_a_match = 1'b1;
        px.netmgmt_vector[0] = 1'b1;
        px.fifo_fill_level = 8'h01;
        px.collision_symbol_rx = 1'b1;
        px.wake_status_field = 3'h1;
        ev.fifo_threshold <= 8'h01;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rd(ccir_pkg::ADDR_ERR_EN_SET, 32'h0);
        bus(1'b1, ccir_pkg::ADDR_ERR_EN_SET, 32'hffff_ffff);
        rd(ccir_pkg::ADDR_ERR_EN_CLR, ccir_pkg::ERR_EN_MASK);
        r = $random(seed);
        bus(1'b1, ccir_pkg::ADDR_ERR_EN_CLR, r);
        rd(ccir_pkg::ADDR_ERR_EN_SET, ccir_pkg::ERR_EN_MASK & ~r);
        rd(32'h0000_0020, 32'h0);
        $display("enable set and clear test done");
        bus(1'b1, ccir_pkg::ADDR_ERR_EN_SET, 32'h1);
        bus(1'b1, ccir_pkg::ADDR_LINE_EN, 32'h3);
        bus(1'b1, ccir_pkg::ADDR_STAT_LSEL, 32'h4);
        stat_en <= 32'h4;
        pulse(pc, 32'h1);
        #1 chk({29'h0, hresp, irq1, irq0}, 32'h3);
        chk({30'h0, seen}, 32'h3);
        rd(ccir_pkg::ADDR_STAT_FLAGS, 32'h4);
        bus(1'b1, ccir_pkg::ADDR_ERR_FLAGS, 32'h1);
        bus(1'b1, ccir_pkg::ADDR_LINE_EN, 32'h1);
        #1 chk({30'h0, irq1, irq0}, 32'h0);
        bus(1'b1, ccir_pkg::ADDR_STAT_FLAGS, 32'hffff_ffff);
        rd(ccir_pkg::ADDR_STAT_FLAGS, 32'h0);
        $display("routing and line enable test done");
        for (int m = 0; m < 6; m++) begin
            ev.poc_state <= m[3:0];
            pulse(pw, 32'h0);
            rd(ccir_pkg::ADDR_STAT_FLAGS, (m >= 1 && m <= 4) ? 32'h0001_0000 : 32'h0);
            bus(1'b1, ccir_pkg::ADDR_STAT_FLAGS, 32'hffff_ffff);
        end
        $display("wake pattern mode test done");
        ev.poc_state <= ccir_pkg::POC_STARTUP;
        @(posedge clk);
        ev.poc_state <= ccir_pkg::POC_NACTIVE;
        pulse(px | pw, 32'h0);
        rd(ccir_pkg::ADDR_STAT_FLAGS, 32'h0200_b9c3);
        $display("event source test done");
        final_report();
    end
endmodule
